//--- hw/pgspi_map.vh
`ifndef PGSPI_MAP_VH
`define PGSPI_MAP_VH
// frame layout, 24 bits msb first
`define PG_FRAME_BITS 5'd24
`define PG_BIT_RW 23
`define PG_BIT_BANK 22
`define PG_BIT_PAGE 21
`define PG_BIT_CH 20
`define PG_ADDR_HI 19
`define PG_ADDR_LO 8
`define PG_A10 18
`define PG_A11 19
// general registers
`define PG_OFS_SOFT_RESET 12'h000
`define PG_OFS_PAGE_ID_LOW 12'h002
`define PG_OFS_PAGE_ID_MID 12'h003
`define PG_OFS_PAGE_ID_HIGH 12'h004
`define PG_OFS_WIRE_SEL 12'h010
`define PG_OFS_CORE_PAGE 12'h011
`define PG_OFS_TOP_PAGE 12'h012
// master page
`define PG_OFS_POWERDOWN 12'h020
`define PG_OFS_CM_IMP 12'h032
`define PG_OFS_CHB_PD_SYNC 12'h039
`define PG_OFS_REF_DEL_HIGH 12'h03c
`define PG_OFS_LANE_SWING 12'h03d
`define PG_OFS_REF_SOURCE 12'h057
`define PG_OFS_SYNC_POL 12'h058
`define PG_OFS_REF_DEL_LOW 12'h05a
// core page
`define PG_OFS_LOW_SPEED_A 12'h03f
`define PG_OFS_LOW_SPEED_B 12'h042
// digital pages
`define PG_OFS_DC_CORR 12'h068
`define PG_OFS_GAIN_TRIM 12'h0a6
`define PG_OFS_DECIM_FACTOR 8'h01
// page selection codes
`define PG_TOP_PAGE_CODE 8'h04
`define PG_CORE_PAGE_CODE 8'hff
`define PG_ID_DC_A 24'h610000
`define PG_ID_DC_B 24'h610100
`define PG_ID_GAIN_A 24'h610005
`define PG_ID_GAIN_B 24'h610105
// reset values
`define PG_RST_BYTE 8'h00
`define PG_RST_ID 24'h000000
`define PG_RST_SEL 2'b00
`endif

//--- hw/pgspi_sync.v
`timescale 1ns/1ps
`default_nettype none
// two flop synchroniser for a pin level
module pgspi_sync #(
  parameter RST_LEVEL = 1'b0
) (
  input wire sys_clk,
  input wire rstn,
  input wire pin_in,
  output wire level_out
);
  reg meta_q;
  reg sync_q;
  // first flop read only by the second
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RST_LEVEL; // matches the pin's idle level, no false edge
      sync_q <= RST_LEVEL;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end
  assign level_out = sync_q;
endmodule // pgspi_sync
`default_nettype wire

//--- hw/pgspi_shift.v
`timescale 1ns/1ps
`default_nettype none
`include "pgspi_map.vh"
// frame shifter: collects 24 bits msb first, shifts readback out
module pgspi_shift (
  input wire sys_clk,
  input wire rstn,
  input wire sen_n_s,
  input wire sclk_s,
  input wire serial_in_line_s,
  input wire [7:0] rd_byte,
  output reg frame_done_q,
  output reg [23:0] frame_q,
  output reg serial_out_line_q,
  output reg rd_req_q,
  output reg [11:0] rd_addr_q
);
  reg sclk_d1_q;
  reg [4:0] cnt_q;
  reg [23:0] sh_q;
  reg [7:0] out_q;
  wire rise = sclk_s & ~sclk_d1_q;
  wire fall = ~sclk_s & sclk_d1_q;
  // count bits, latch frame on the 24th rising edge
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d1_q <= 1'b0;
      cnt_q <= 5'd0;
      sh_q <= 24'h000000;
      frame_q <= 24'h000000;
      frame_done_q <= 1'b0;
      out_q <= 8'h00;
      serial_out_line_q <= 1'b0;
      rd_req_q <= 1'b0;
      rd_addr_q <= 12'h000;
    end else begin
      sclk_d1_q <= sclk_s;
      frame_done_q <= 1'b0;
      rd_req_q <= 1'b0;
      if (sen_n_s) begin
        cnt_q <= 5'd0;
        serial_out_line_q <= 1'b0;
      end else begin
        if (rise && cnt_q < `PG_FRAME_BITS) begin
          sh_q <= {sh_q[22:0], serial_in_line_s};
          cnt_q <= cnt_q + 5'd1;
          if (cnt_q == `PG_FRAME_BITS - 5'd9) begin
            rd_req_q <= 1'b1; // address complete, fetch readback byte
            rd_addr_q <= {sh_q[10:0], serial_in_line_s};
          end
          if (cnt_q == `PG_FRAME_BITS - 5'd1) begin
            frame_q <= {sh_q[22:0], serial_in_line_s};
            frame_done_q <= 1'b1;
          end
        end
        if (rd_req_q)
          out_q <= rd_byte;
        // data out changes on falling edge
        if (fall && cnt_q >= `PG_FRAME_BITS - 5'd8 && cnt_q < `PG_FRAME_BITS) begin
          serial_out_line_q <= out_q[7];
          out_q <= {out_q[6:0], 1'b0};
        end
      end
    end
  end
endmodule // pgspi_shift
`default_nettype wire

//--- hw/pgspi_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pgspi_map.vh"
module pgspi_top (
  input wire sys_clk,
  input wire rstn,
  input wire serial_enable_n,
  input wire serial_clk,
  input wire serial_in_line,
  output reg serial_out_line,
  output reg serial_out_oe,
  output reg soft_reset_pulse_q,
  output reg wire_mode_q,
  output reg full_powerdown_q,
  output reg second_channel_powerdown_q,
  output reg frame_ref_powerdown_q,
  output reg second_channel_pd_allow_q,
  output reg sync_termination_off_q,
  output reg common_mode_impedance_up_q,
  output reg frame_ref_delay_on_q,
  output reg [4:0] frame_ref_delay_code_q,
  output reg [2:0] lane_swing_code_q,
  output reg frame_ref_from_register_q,
  output reg frame_ref_force_high_q,
  output reg link_sync_invert_q,
  output reg low_speed_enable_a_q,
  output reg low_speed_enable_b_q,
  output reg dc_correction_off_a_q,
  output reg dc_correction_off_b_q,
  output reg [3:0] output_gain_trim_a_q,
  output reg [3:0] output_gain_trim_b_q,
  output reg [3:0] decim_factor_a_q,
  output reg [3:0] decim_factor_b_q,
  output reg [23:0] active_page_id_q,
  output reg direct_wr_pulse_q,
  output reg [1:0] direct_wr_target_q,
  output reg [7:0] direct_wr_addr_q,
  output reg [7:0] direct_wr_data_q
);
  wire sen_n_s;
  wire sclk_s;
  wire serial_in_line_s;
  wire frame_done;
  wire [23:0] frame;
  wire serial_out_line_w;
  wire [11:0] rd_addr;
  reg [7:0] rd_byte;

  // pins pass two flops before use
  pgspi_sync #(.RST_LEVEL(1'b1)) u_sync_sen (.sys_clk(sys_clk), .rstn(rstn),
    .pin_in(serial_enable_n), .level_out(sen_n_s)); // enable idles high
  pgspi_sync u_sync_clk (.sys_clk(sys_clk), .rstn(rstn), .pin_in(serial_clk),
    .level_out(sclk_s));
  pgspi_sync u_sync_din (.sys_clk(sys_clk), .rstn(rstn), .pin_in(serial_in_line),
    .level_out(serial_in_line_s));

  // frame shifter, its readback request stays inside it
  pgspi_shift u_shift (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .sen_n_s(sen_n_s),
    .sclk_s(sclk_s),
    .serial_in_line_s(serial_in_line_s),
    .rd_byte(rd_byte),
    .frame_done_q(frame_done),
    .frame_q(frame),
    .serial_out_line_q(serial_out_line_w),
    .rd_req_q(),
    .rd_addr_q(rd_addr)
  );

  // page selection state
  reg [7:0] page_id_low_q;
  reg [7:0] page_id_mid_q;
  reg [7:0] page_id_high_q;
  reg [7:0] core_page_q;
  reg [7:0] top_page_q;
  // frame activity seen one cycle, masks a lone glitch on the enable
  reg frame_on_q;

  // frame fields
  wire f_write = ~frame[`PG_BIT_RW];
  wire f_bank = frame[`PG_BIT_BANK];
  wire f_regacc = frame[`PG_BIT_PAGE];
  wire f_ch = frame[`PG_BIT_CH];
  wire [11:0] f_addr = frame[`PG_ADDR_HI:`PG_ADDR_LO];
  wire [7:0] f_data = frame[7:0];

  // direct access: bank one and channel one, any page bit
  wire f_direct = f_bank & f_ch;
  wire f_wr = frame_done & f_write;

  // general registers live outside pages, reached with the page bit zero
  function is_general;
    input [11:0] a;
    begin
      is_general = (a == `PG_OFS_SOFT_RESET) || (a == `PG_OFS_PAGE_ID_LOW) ||
        (a == `PG_OFS_PAGE_ID_MID) || (a == `PG_OFS_PAGE_ID_HIGH) ||
        (a == `PG_OFS_WIRE_SEL) || (a == `PG_OFS_CORE_PAGE) || (a == `PG_OFS_TOP_PAGE);
    end
  endfunction

  wire top_sel = (top_page_q == `PG_TOP_PAGE_CODE);
  wire core_sel = (core_page_q == `PG_CORE_PAGE_CODE);
  wire [23:0] cur_id = {page_id_high_q, page_id_mid_q, page_id_low_q};
  // channel bit not consulted on analog writes, digital paged writes need it low
  wire an_wr = f_wr & ~f_bank;
  wire dg_wr = f_wr & f_bank & ~f_direct & f_regacc;
  wire dg_pg = f_wr & f_bank & ~f_direct & ~f_regacc;

  // page select registers and general controls
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      page_id_low_q <= `PG_RST_BYTE;
      page_id_mid_q <= `PG_RST_BYTE;
      page_id_high_q <= `PG_RST_BYTE;
      core_page_q <= `PG_RST_BYTE;
      top_page_q <= `PG_RST_BYTE;
      wire_mode_q <= 1'b0;
      soft_reset_pulse_q <= 1'b0;
      active_page_id_q <= `PG_RST_ID;
    end else begin
      soft_reset_pulse_q <= 1'b0;
      active_page_id_q <= cur_id;
      // page id bytes, one per frame, held until rewritten
      if (dg_pg && f_addr == `PG_OFS_PAGE_ID_LOW)
        page_id_low_q <= f_data;
      if (dg_pg && f_addr == `PG_OFS_PAGE_ID_MID)
        page_id_mid_q <= f_data;
      if (dg_pg && f_addr == `PG_OFS_PAGE_ID_HIGH)
        page_id_high_q <= f_data;
      // analog page selection
      if (an_wr && !f_regacc && f_addr == `PG_OFS_CORE_PAGE)
        core_page_q <= f_data;
      if (an_wr && !f_regacc && f_addr == `PG_OFS_TOP_PAGE)
        top_page_q <= f_data;
      if (f_wr && !f_direct && !f_regacc && f_addr == `PG_OFS_WIRE_SEL)
        wire_mode_q <= f_data[0];
      if (f_wr && !f_direct && !f_regacc && f_addr == `PG_OFS_SOFT_RESET)
        soft_reset_pulse_q <= f_data[0] | f_data[7];
    end
  end

  // analog bank registers in master and core pages
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      full_powerdown_q <= 1'b0;
      second_channel_powerdown_q <= 1'b0;
      frame_ref_powerdown_q <= 1'b0;
      second_channel_pd_allow_q <= 1'b0;
      sync_termination_off_q <= 1'b0;
      common_mode_impedance_up_q <= 1'b0;
      frame_ref_delay_on_q <= 1'b0;
      frame_ref_delay_code_q <= 5'd0;
      lane_swing_code_q <= 3'd0;
      frame_ref_from_register_q <= 1'b0;
      frame_ref_force_high_q <= 1'b0;
      link_sync_invert_q <= 1'b0;
      low_speed_enable_a_q <= 1'b0;
      low_speed_enable_b_q <= 1'b0;
    end else if (an_wr && f_regacc && !is_general(f_addr)) begin
      if (top_sel) begin
        case (f_addr)
          `PG_OFS_POWERDOWN: begin
            full_powerdown_q <= f_data[0];
            second_channel_powerdown_q <= f_data[1];
            frame_ref_powerdown_q <= f_data[4];
          end
          `PG_OFS_CM_IMP: common_mode_impedance_up_q <= f_data[5];
          `PG_OFS_CHB_PD_SYNC: begin
            sync_termination_off_q <= f_data[0];
            second_channel_pd_allow_q <= f_data[1];
          end
          `PG_OFS_REF_DEL_HIGH: begin
            frame_ref_delay_on_q <= f_data[6];
            frame_ref_delay_code_q[4:3] <= f_data[1:0];
          end
          `PG_OFS_REF_DEL_LOW: frame_ref_delay_code_q[2:0] <= f_data[7:5];
          `PG_OFS_LANE_SWING: lane_swing_code_q <= f_data[2:0];
          `PG_OFS_REF_SOURCE: begin
            frame_ref_from_register_q <= f_data[4];
            frame_ref_force_high_q <= f_data[3];
          end
          `PG_OFS_SYNC_POL: link_sync_invert_q <= f_data[5];
          default: ;
        endcase
      end
      if (core_sel) begin
        case (f_addr)
          `PG_OFS_LOW_SPEED_A: low_speed_enable_a_q <= f_data[2];
          `PG_OFS_LOW_SPEED_B: low_speed_enable_b_q <= f_data[4];
          default: ;
        endcase
      end
    end
  end

  // digital bank paged registers, target set by stored page id
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dc_correction_off_a_q <= 1'b0;
      dc_correction_off_b_q <= 1'b0;
      output_gain_trim_a_q <= 4'd0;
      output_gain_trim_b_q <= 4'd0;
    end else if (dg_wr) begin
      if (cur_id == `PG_ID_DC_A && f_addr == `PG_OFS_DC_CORR)
        dc_correction_off_a_q <= f_data[2];
      if (cur_id == `PG_ID_DC_B && f_addr == `PG_OFS_DC_CORR)
        dc_correction_off_b_q <= f_data[2];
      if (cur_id == `PG_ID_GAIN_A && f_addr == `PG_OFS_GAIN_TRIM)
        output_gain_trim_a_q <= f_data[3:0];
      if (cur_id == `PG_ID_GAIN_B && f_addr == `PG_OFS_GAIN_TRIM)
        output_gain_trim_b_q <= f_data[3:0];
    end
  end

  // direct writes: one frame, no page step, page id untouched
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      decim_factor_a_q <= 4'd0;
      decim_factor_b_q <= 4'd0;
      direct_wr_pulse_q <= 1'b0;
      direct_wr_target_q <= `PG_RST_SEL;
      direct_wr_addr_q <= 8'h00;
      direct_wr_data_q <= 8'h00;
    end else begin
      direct_wr_pulse_q <= 1'b0;
      if (f_wr && f_direct) begin
        direct_wr_pulse_q <= 1'b1;
        // target: bit1 detector page, bit0 channel B
        direct_wr_target_q <= {frame[`PG_A10], frame[`PG_A11]};
        direct_wr_addr_q <= f_addr[7:0];
        direct_wr_data_q <= f_data;
        if (!frame[`PG_A10] && f_addr[7:0] == `PG_OFS_DECIM_FACTOR) begin
          if (frame[`PG_A11])
            decim_factor_b_q <= f_data[3:0];
          else
            decim_factor_a_q <= f_data[3:0];
        end
      end
    end
  end

  // frame activity flag, follows the synced enable one cycle late
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frame_on_q <= 1'b0;
    end else if (sen_n_s) begin
      frame_on_q <= 1'b0;
    end else begin
      frame_on_q <= 1'b1;
    end
  end

  // readback mux: page id, page selects and wire select, plus master powerdown and lane swing only
  always @* begin
    rd_byte = 8'h00;
    case (rd_addr)
      `PG_OFS_PAGE_ID_LOW: rd_byte = page_id_low_q;
      `PG_OFS_PAGE_ID_MID: rd_byte = page_id_mid_q;
      `PG_OFS_PAGE_ID_HIGH: rd_byte = page_id_high_q;
      `PG_OFS_WIRE_SEL: rd_byte = {7'd0, wire_mode_q};
      `PG_OFS_CORE_PAGE: rd_byte = core_page_q;
      `PG_OFS_TOP_PAGE: rd_byte = top_page_q;
      `PG_OFS_POWERDOWN: rd_byte = {3'd0, frame_ref_powerdown_q, 2'd0,
        second_channel_powerdown_q, full_powerdown_q};
      `PG_OFS_LANE_SWING: rd_byte = {5'd0, lane_swing_code_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // serial out registered, enabled while frame active
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      serial_out_line <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_line <= serial_out_line_w;
      serial_out_oe <= ~sen_n_s & frame_on_q;
    end
  end
endmodule // pgspi_top
`default_nettype wire

//--- testbench/pgspi_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "pgspi_map.vh"
// watches direct and paged write results at the top ports
module pgspi_top_monitor (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic serial_enable_n,
  input wire logic serial_out_oe,
  input wire logic direct_wr_pulse_q,
  input wire logic [1:0] direct_wr_target_q,
  input wire logic [7:0] direct_wr_addr_q,
  input wire logic [7:0] direct_wr_data_q,
  input wire logic [3:0] decim_factor_a_q,
  input wire logic [3:0] decim_factor_b_q,
  input wire logic [23:0] active_page_id_q,
  input wire logic dc_correction_off_a_q,
  input wire logic [3:0] output_gain_trim_a_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // strobe and frame relations
  a_pulse_one_cycle: assert property (direct_wr_pulse_q |=> !direct_wr_pulse_q)
    else $error("direct write strobe held too long");
  a_pulse_in_frame: assert property (direct_wr_pulse_q |-> !$past(serial_enable_n, 2))
    else $error("direct write strobe outside a frame");
  a_oe_in_frame: assert property (serial_out_oe |-> !$past(serial_enable_n, 3))
    else $error("serial output enabled outside a frame");
  a_page_held_direct: assert property (direct_wr_pulse_q |=> $stable(active_page_id_q) [*3])
    else $error("direct write moved the selected page");
  a_direct_no_paged: assert property (direct_wr_pulse_q |->
    $stable(dc_correction_off_a_q) && $stable(output_gain_trim_a_q))
    else $error("direct write touched a paged register");
  // decimation registers follow direct writes only
  a_decim_a_source: assert property ($changed(decim_factor_a_q) |->
    direct_wr_pulse_q && direct_wr_target_q == 2'b00)
    else $error("channel a decimation changed without its direct write");
  a_decim_b_source: assert property ($changed(decim_factor_b_q) |->
    direct_wr_pulse_q && direct_wr_target_q == 2'b01)
    else $error("channel b decimation changed without its direct write");
  a_decim_value: assert property (direct_wr_pulse_q && direct_wr_target_q == 2'b00 &&
    direct_wr_addr_q == 8'h01 |-> decim_factor_a_q == direct_wr_data_q[3:0])
    else $error("channel a decimation value wrong");
  // paged registers only change inside their page
  a_dc_needs_page: assert property ($changed(dc_correction_off_a_q) |->
    active_page_id_q == `PG_ID_DC_A)
    else $error("offset register written outside its page");
  a_gain_needs_page: assert property ($changed(output_gain_trim_a_q) |->
    active_page_id_q == `PG_ID_GAIN_A)
    else $error("gain register written outside its page");
endmodule // pgspi_top_monitor

bind pgspi_top pgspi_top_monitor mon_u (
  .sys_clk(sys_clk), .rstn(rstn), .serial_enable_n(serial_enable_n),
  .serial_out_oe(serial_out_oe),
  .direct_wr_pulse_q(direct_wr_pulse_q), .direct_wr_target_q(direct_wr_target_q),
  .direct_wr_addr_q(direct_wr_addr_q), .direct_wr_data_q(direct_wr_data_q),
  .decim_factor_a_q(decim_factor_a_q), .decim_factor_b_q(decim_factor_b_q),
  .active_page_id_q(active_page_id_q), .dc_correction_off_a_q(dc_correction_off_a_q),
  .output_gain_trim_a_q(output_gain_trim_a_q)
);
`default_nettype wire

//--- testbench/pgspi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host serial controller, clock idles low between frames
module pgspi_host_model (
  input wire logic sys_clk,
  output logic serial_enable_n,
  output logic serial_clk,
  output logic serial_in_line
);
  // idle levels at time zero
  initial begin
    serial_enable_n = 1'b1;
    serial_clk = 1'b0;
    serial_in_line = 1'b0;
  end
  // one frame, msb first, cut short when nbits is below 24
  task automatic send(input logic [23:0] f, input int nbits, input int half);
    @(posedge sys_clk);
    serial_enable_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      repeat (half) @(posedge sys_clk);
      serial_clk <= 1'b0;
      serial_in_line <= f[23 - i];
      repeat (half) @(posedge sys_clk);
      serial_clk <= 1'b1;
    end
    repeat (half) @(posedge sys_clk);
    serial_clk <= 1'b0;
    serial_in_line <= ~serial_in_line; // released line shows no stale bit
    repeat (half) @(posedge sys_clk);
    serial_enable_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // pgspi_host_model
`default_nettype wire

//--- testbench/test_paged_spi_register_addressing.sv
`timescale 1ns/1ps
`default_nettype none
// regression of direct and paged writes through the serial port
module test_paged_spi_register_addressing;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  wire logic serial_enable_n, serial_clk, serial_in_line, serial_out_line, serial_out_oe;
  wire logic full_powerdown_q, second_channel_powerdown_q, low_speed_enable_a_q;
  wire logic dc_correction_off_a_q, dc_correction_off_b_q, direct_wr_pulse_q;
  wire logic soft_reset_pulse_q, wire_mode_q, frame_ref_powerdown_q, low_speed_enable_b_q;
  wire logic second_channel_pd_allow_q, sync_termination_off_q, common_mode_impedance_up_q;
  wire logic frame_ref_delay_on_q, frame_ref_from_register_q, frame_ref_force_high_q;
  wire logic link_sync_invert_q;
  wire logic [2:0] lane_swing_code_q;
  wire logic [4:0] frame_ref_delay_code_q;
  wire logic [3:0] output_gain_trim_a_q, output_gain_trim_b_q;
  wire logic [3:0] decim_factor_a_q, decim_factor_b_q;
  // master page fields packed for one comparison
  wire logic [14:0] master_bits = {lane_swing_code_q, frame_ref_delay_on_q,
    frame_ref_delay_code_q, frame_ref_from_register_q, frame_ref_force_high_q,
    link_sync_invert_q, common_mode_impedance_up_q, sync_termination_off_q,
    second_channel_pd_allow_q};
  wire logic [23:0] active_page_id_q;
  wire logic [1:0] direct_wr_target_q;
  wire logic [7:0] direct_wr_addr_q, direct_wr_data_q;
  int num_errors = 0;
  int checks_done = 0;
  int pulses = 0;
  int resets = 0;
  logic [23:0] rd_cap = 24'h000000;
  logic rd_oe = 1'b0;
  logic [1:0] last_tgt = 2'b00;
  logic [7:0] last_addr = 8'h00;
  logic [7:0] last_data = 8'h00;
  logic [23:0] dfr [4] = '{24'h500102, 24'h580105, 24'h540311, 24'h5c0377};
  logic [1:0] dtg [4] = '{2'b00, 2'b01, 2'b10, 2'b11};

  // sampling clock kept running throughout
  always #25 sys_clk = ~sys_clk;

  pgspi_host_model host_u (.sys_clk(sys_clk), .serial_enable_n(serial_enable_n),
    .serial_clk(serial_clk), .serial_in_line(serial_in_line));

  pgspi_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .serial_enable_n(serial_enable_n),
    .serial_clk(serial_clk), .serial_in_line(serial_in_line),
    .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
    .soft_reset_pulse_q(soft_reset_pulse_q), .wire_mode_q(wire_mode_q),
    .full_powerdown_q(full_powerdown_q),
    .second_channel_powerdown_q(second_channel_powerdown_q),
    .frame_ref_powerdown_q(frame_ref_powerdown_q),
    .second_channel_pd_allow_q(second_channel_pd_allow_q),
    .sync_termination_off_q(sync_termination_off_q),
    .common_mode_impedance_up_q(common_mode_impedance_up_q),
    .frame_ref_delay_on_q(frame_ref_delay_on_q),
    .frame_ref_delay_code_q(frame_ref_delay_code_q),
    .lane_swing_code_q(lane_swing_code_q),
    .frame_ref_from_register_q(frame_ref_from_register_q),
    .frame_ref_force_high_q(frame_ref_force_high_q),
    .link_sync_invert_q(link_sync_invert_q),
    .low_speed_enable_a_q(low_speed_enable_a_q),
    .low_speed_enable_b_q(low_speed_enable_b_q),
    .dc_correction_off_a_q(dc_correction_off_a_q),
    .dc_correction_off_b_q(dc_correction_off_b_q),
    .output_gain_trim_a_q(output_gain_trim_a_q),
    .output_gain_trim_b_q(output_gain_trim_b_q),
    .decim_factor_a_q(decim_factor_a_q), .decim_factor_b_q(decim_factor_b_q),
    .active_page_id_q(active_page_id_q), .direct_wr_pulse_q(direct_wr_pulse_q),
    .direct_wr_target_q(direct_wr_target_q), .direct_wr_addr_q(direct_wr_addr_q),
    .direct_wr_data_q(direct_wr_data_q));

  // capture of direct write and soft reset strobes
  always @(posedge sys_clk) begin
    if (direct_wr_pulse_q === 1'b1) begin
      pulses <= pulses + 1;
      last_tgt <= direct_wr_target_q;
      last_addr <= direct_wr_addr_q;
      last_data <= direct_wr_data_q;
    end
    if (soft_reset_pulse_q === 1'b1) begin
      resets <= resets + 1;
    end
  end

  // readback bits taken at the host's rising serial clock
  always @(posedge serial_clk) begin
    if (serial_enable_n === 1'b0) begin
      rd_cap <= {rd_cap[22:0], serial_out_line};
      rd_oe <= serial_out_oe;
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [23:0] f);
    host_u.send(f, 24, 4);
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #1000000;
    num_errors++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    stop_test();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(active_page_id_q, 24'h000000);
    chk(24'(decim_factor_a_q), 24'h0);
    // every direct page and channel, page bit low
    for (int i = 0; i < 4; i++) begin
      wr(dfr[i]);
      chk(24'(pulses), 24'(i + 1));
      chk(24'(last_tgt), 24'(dtg[i]));
      chk(24'(last_data), 24'(dfr[i][7:0]));
    end
    chk(24'(decim_factor_a_q), 24'h2);
    chk(24'(decim_factor_b_q), 24'h5);
    chk(24'(last_addr), 24'h3);
    // cut-short frame is dropped, slow frame lands
    host_u.send(24'h50010f, 12, 4);
    chk(24'(pulses), 24'h4);
    host_u.send(24'h50010a, 24, 7);
    chk(24'(decim_factor_a_q), 24'ha);
    // digital bank offset and gain pages
    wr(24'h400461);
    wr(24'h400300);
    wr(24'h400200);
    chk(active_page_id_q, 24'h610000);
    wr(24'h606804);
    chk({22'h0, dc_correction_off_b_q, dc_correction_off_a_q}, 24'h1);
    wr(24'h50010c);
    chk(active_page_id_q, 24'h610000);
    wr(24'h606800);
    chk(24'(dc_correction_off_a_q), 24'h0);
    wr(24'h60a603);
    chk(24'(output_gain_trim_a_q), 24'h0);
    wr(24'h400205);
    wr(24'h60a609);
    chk(24'(output_gain_trim_a_q), 24'h9);
    wr(24'h400301);
    wr(24'h60a60c);
    chk({16'h0, output_gain_trim_b_q, output_gain_trim_a_q}, 24'hc9);
    // general registers reached with the page bit low
    wr(24'h001001);
    chk(24'(wire_mode_q), 24'h1);
    wr(24'h000081);
    chk(24'(resets), 24'h1);
    // analog bank with channel bit set
    wr(24'h001204);
    wr(24'h302013);
    chk({22'h0, second_channel_powerdown_q, full_powerdown_q}, 24'h3);
    chk(24'(frame_ref_powerdown_q), 24'h1);
    // read frame runs slower so each bit is settled at the host's edge
    host_u.send(24'ha02000, 24, 6);
    chk({16'h0, rd_cap[7:0]}, 24'h13);
    chk({23'h0, rd_oe}, 24'h1);
    chk({23'h0, serial_out_oe}, 24'h0);
    chk(24'(full_powerdown_q), 24'h1);
    // master page fields
    wr(24'h203d05);
    wr(24'h203c42);
    wr(24'h205aa0);
    wr(24'h205718);
    wr(24'h205820);
    wr(24'h203220);
    wr(24'h203953);
    chk({9'h0, master_bits}, 24'h005d7f);
    // core page only, master page dropped
    wr(24'h0011ff);
    wr(24'h001200);
    wr(24'h203f04);
    wr(24'h204213);
    chk({22'h0, low_speed_enable_b_q, low_speed_enable_a_q}, 24'h3);
    wr(24'h202000);
    chk(24'(full_powerdown_q), 24'h1);
    wr(24'h001204);
    wr(24'h202000);
    chk(24'(full_powerdown_q), 24'h0);
    // second reset clears selection and direct settings
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(active_page_id_q, 24'h000000);
    chk(24'(decim_factor_a_q), 24'h0);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    stop_test();
  end
endmodule // test_paged_spi_register_addressing
`default_nettype wire
